// ===== hdl/io_input_select_readport.sv
/*
  Port-side input source selection, keyed read-port read-back, port data
  and direction latches, bit read-modify-write, A/D path switches and
  Port A wake-up. Assumes a byte register port with read data one cycle
  after the read strobe, pin function classes supplied by the pin-shared
  selection logic, and a sleep level from the power controller.
*/
`timescale 1ns/1ps
module io_input_select_readport
  import io_sel_pkg::*;
#(
  parameter int NUM_PORTS = 5,
  parameter int NUM_AN = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [7:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [7:0] bus_rdata_out,
  // Pads and pin function classes
  input wire logic [NUM_PORTS*8-1:0] pin_level_in,
  input wire logic [NUM_PORTS*8-1:0] pin_periph_out_in,
  input wire logic [NUM_PORTS*8-1:0] pin_comm_in,
  input wire logic [NUM_PORTS*8-1:0] pin_analog_in,
  input wire logic [NUM_PORTS*8-1:0] pin_reset_in,
  output logic [NUM_PORTS*8-1:0] port_data_out,
  output logic [NUM_PORTS*8-1:0] port_oe_out,
  // A/D path control
  input wire logic [NUM_AN-1:0] an_func_sel_in,
  input wire logic [NUM_AN-1:0] an_chan_sel_in,
  output logic [NUM_AN-1:0] an_switch_out,
  // Routed peripheral inputs
  output logic std_timer0_capture_out,
  output logic std_timer1_capture_out,
  output logic chip_select_out,
  output logic serial_data_out,
  output logic serial_clock_out,
  output logic ext_irq0_out,
  output logic ext_irq1_out,
  output logic ext_irq2_out,
  output logic ext_irq3_out,
  output logic uart0_rx_out,
  output logic uart1_rx_out,
  // Read-port state and wake-up
  output logic read_port_enable_out,
  input wire logic sleep_in,
  output logic wake_out
);

  localparam int NPIN = NUM_PORTS * 8;

  // Settled pin levels from the synchroniser
  pin_bus_if #(.WIDTH(NPIN)) pins ();
  assign pins.raw = pin_level_in;

  pin_sync #(.WIDTH(NPIN)) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .pins(pins)
  );

  wire [NPIN-1:0] pin_w = pins.stable; // Settled pin levels

  // Software registers
  logic [7:0] input_select_one_reg;
  logic [7:0] input_select_two_reg;
  logic [7:0] input_select_three_reg;
  logic [7:0] read_port_key_reg;
  logic [7:0] wake_en_reg; // Port A wake-up enables
  logic read_port_enable_reg; // Decoded unlock flag
  logic [7:0] rdata_reg;
  logic [NPIN-1:0] data_reg; // Output data latches
  logic [NPIN-1:0] dir_reg; // 1 = input, 0 = output
  logic [NPIN-1:0] oe_reg; // Pad drive enable, kept beside dir_reg
  logic [NUM_AN-1:0] an_sw_reg;
  logic [10:0] route_reg; // Routed peripheral inputs
  logic [7:0] pa_prev_reg; // Port A levels one cycle ago
  logic wake_reg;

  // Address decode
  wire hit_one = bus_addr_in == OFS_SEL_ONE;
  wire hit_two = bus_addr_in == OFS_SEL_TWO;
  wire hit_three = bus_addr_in == OFS_SEL_THREE;
  wire hit_key = bus_addr_in == OFS_KEY;
  wire hit_wake = bus_addr_in == OFS_WAKE_EN;
  wire hit_bop = bus_addr_in == OFS_BIT_OP;
  wire [2:0] port_idx = bus_addr_in[2:0];
  wire idx_ok = 32'(port_idx) < NUM_PORTS;
  wire hit_data = (bus_addr_in[7:3] == OFS_DATA_BLK) && idx_ok;
  wire hit_dir = (bus_addr_in[7:3] == OFS_DIR_BLK) && idx_ok;

  // Bit-operation command fields
  wire bop_dir = bus_wdata_in[BOP_DIR_BIT];
  wire [2:0] bop_port = bus_wdata_in[BOP_PORT_LSB +: 3];
  wire bop_val = bus_wdata_in[BOP_VAL_BIT];
  wire [2:0] bop_bit = bus_wdata_in[2:0];
  wire bop_go = bus_wr_in && hit_bop;

  // Unlock is a pure compare; writing any other pattern turns it off
  wire key_match = bus_wdata_in == READ_PORT_KEY_VAL;

  // Per-pin read-back value and analog isolation
  logic [NPIN-1:0] rb_w;
  genvar i;
  generate
    for (i = 0; i < NPIN; i++) begin : g_rb
      wire an_or_rst = pin_analog_in[i] || pin_reset_in[i];
      wire dir_in = dir_reg[i];
      // Analog and reset pins never expose a digital level
      assign rb_w[i] = an_or_rst ? 1'b0 :
                       read_port_enable_reg ? pin_w[i] :
                       pin_comm_in[i] ? (dir_in ? pin_w[i] : data_reg[i]) :
                       pin_periph_out_in[i] ? (dir_in ? 1'b0 : data_reg[i]) :
                       (dir_in ? pin_w[i] : data_reg[i]);
    end
  endgenerate

  // Per-port latch next values, including read-modify-write
  logic [NPIN-1:0] data_next;
  logic [NPIN-1:0] dir_next;
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      wire sel_p = 32'(port_idx) == p;
      wire bop_p = bop_go && (32'(bop_port) == p);
      // The whole byte is read first: input pins copy their rb_w read-back value into the latch
      wire [7:0] rd_byte = bop_dir ? dir_reg[p*8 +: 8] : rb_w[p*8 +: 8];
      wire [7:0] bit_mask = 8'h01 << bop_bit;
      wire [7:0] rmw_byte = bop_val ? (rd_byte | bit_mask) : (rd_byte & ~bit_mask);
      assign data_next[p*8 +: 8] = (bus_wr_in && hit_data && sel_p) ? bus_wdata_in :
                                   (bop_p && !bop_dir) ? rmw_byte : data_reg[p*8 +: 8];
      assign dir_next[p*8 +: 8] = (bus_wr_in && hit_dir && sel_p) ? bus_wdata_in :
                                  (bop_p && bop_dir) ? rmw_byte : dir_reg[p*8 +: 8];
    end
  endgenerate

  // Read multiplexer; unmapped addresses read zero
  wire [7:0] port_rb_byte = rb_w[32'(port_idx)*8 +: 8];
  wire [7:0] port_dir_byte = dir_reg[32'(port_idx)*8 +: 8];
  wire [7:0] rd_mux = hit_one ? input_select_one_reg :
                      hit_two ? input_select_two_reg :
                      hit_three ? input_select_three_reg :
                      hit_key ? read_port_key_reg :
                      hit_wake ? wake_en_reg :
                      hit_data ? port_rb_byte :
                      hit_dir ? port_dir_byte : UNMAPPED_READ;

  // Source selection; reserved codes yield the idle level
  wire [7:0] s1 = input_select_one_reg;
  wire [7:0] s2 = input_select_two_reg;
  wire [7:0] s3 = input_select_three_reg;
  wire cap0_w = s1[CAP0_SRC_BIT] ? pin_w[PORT_E_PIN1] : pin_w[PORT_C_PIN6];
  wire cap1_w = s1[CAP1_SRC_BIT] ? pin_w[PORT_B_PIN6] : IDLE_LEVEL;
  wire cs_w = s2[CS_SRC_BIT] ? IDLE_LEVEL : pin_w[PORT_A_PIN1];
  wire sdata_w = s2[SDATA_SRC_BIT] ? IDLE_LEVEL : pin_w[PORT_A_PIN4];
  wire sclk_w = s2[SCLK_SRC_BIT] ? IDLE_LEVEL : pin_w[PORT_A_PIN5];
  wire irq3_w = s2[IRQ3_SRC_BIT] ? pin_w[PORT_C_PIN7] : pin_w[PORT_A_PIN5];
  wire irq2_w = s2[IRQ2_SRC_BIT] ? IDLE_LEVEL : pin_w[PORT_A_PIN4];
  wire irq1_w = s2[IRQ1_SRC_BIT] ? pin_w[PORT_A_PIN7] : pin_w[PORT_A_PIN3];
  wire irq0_w = s2[IRQ0_SRC_BIT] ? pin_w[PORT_A_PIN6] : pin_w[PORT_A_PIN1];
  wire urx1_w = s3[URX1_SRC_BIT] ? pin_w[PORT_F_PIN6] : IDLE_LEVEL;
  wire urx0_w = s3[URX0_SRC_BIT] ? IDLE_LEVEL : pin_w[PORT_A_PIN6];
  wire [10:0] route_next = {urx1_w, urx0_w, irq3_w, irq2_w, irq1_w, irq0_w,
                            sclk_w, sdata_w, cs_w, cap1_w, cap0_w};

  // A/D switch: selected channel, and function selected or read-port forced
  wire [NUM_AN-1:0] an_sw_next = an_chan_sel_in &
                                 (an_func_sel_in | {NUM_AN{read_port_enable_reg}});

  // Port A wake-up: enabled falling edges, only while asleep
  wire [7:0] pa_w = pin_w[7:0];
  wire [7:0] pa_fall = pa_prev_reg & ~pa_w & wake_en_reg;
  wire wake_next = sleep_in && (|pa_fall);

  // Selection, key and wake-enable registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      input_select_one_reg <= RST_SEL;
      input_select_two_reg <= RST_SEL;
      input_select_three_reg <= RST_SEL;
      read_port_key_reg <= RST_KEY;
      read_port_enable_reg <= 1'b0;
      wake_en_reg <= RST_WAKE_EN;
    end else if (bus_wr_in) begin
      // Masks keep unimplemented bits at zero
      if (hit_one) input_select_one_reg <= bus_wdata_in & MASK_SEL_ONE;
      if (hit_two) input_select_two_reg <= bus_wdata_in & MASK_SEL_TWO;
      if (hit_three) input_select_three_reg <= bus_wdata_in & MASK_SEL_THREE;
      if (hit_key) begin
        read_port_key_reg <= bus_wdata_in;
        read_port_enable_reg <= key_match;
      end
      if (hit_wake) wake_en_reg <= bus_wdata_in;
    end
  end

  // Data and direction latches start all high: inputs, and high once made outputs; drive enables start low
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_reg <= {NUM_PORTS{RST_PORT}};
      dir_reg <= {NUM_PORTS{RST_PORT}};
      oe_reg <= '0;
    end else begin
      data_reg <= data_next;
      dir_reg <= dir_next;
      oe_reg <= ~dir_next;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= UNMAPPED_READ;
    end else begin
      rdata_reg <= bus_rd_in ? rd_mux : UNMAPPED_READ;
    end
  end

  // Routed inputs, analog switches and wake pulse
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      route_reg <= {11{IDLE_LEVEL}};
      an_sw_reg <= '0;
      pa_prev_reg <= {8{IDLE_LEVEL}};
      wake_reg <= 1'b0;
    end else begin
      route_reg <= route_next;
      an_sw_reg <= an_sw_next;
      pa_prev_reg <= pa_w;
      wake_reg <= wake_next;
    end
  end

  // Outputs straight from flip-flops
  assign bus_rdata_out = rdata_reg;
  assign port_data_out = data_reg;
  assign port_oe_out = oe_reg;
  assign an_switch_out = an_sw_reg;
  assign read_port_enable_out = read_port_enable_reg;
  assign wake_out = wake_reg;
  assign std_timer0_capture_out = route_reg[0];
  assign std_timer1_capture_out = route_reg[1];
  assign chip_select_out = route_reg[2];
  assign serial_data_out = route_reg[3];
  assign serial_clock_out = route_reg[4];
  assign ext_irq0_out = route_reg[5];
  assign ext_irq1_out = route_reg[6];
  assign ext_irq2_out = route_reg[7];
  assign ext_irq3_out = route_reg[8];
  assign uart0_rx_out = route_reg[9];
  assign uart1_rx_out = route_reg[10];

  // Checks, all on the system clock
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  AST_KEY_ON: assert property (bus_wr_in && hit_key && key_match
    |=> read_port_enable_out)
    else $error("read-port not enabled by key pattern");
  AST_KEY_OFF: assert property (bus_wr_in && hit_key && !key_match |=> !read_port_enable_out)
    else $error("read-port enabled by wrong pattern");
  AST_SEL3_RSVD: assert property (bus_rd_in && hit_three |=> bus_rdata_out[7:2] == 6'h00)
    else $error("unimplemented select bits read nonzero");
  AST_IRQ0_A6: assert property (input_select_two_reg[IRQ0_SRC_BIT] && pin_w[PORT_A_PIN6]
    && !(bus_wr_in && hit_two) |=> ext_irq0_out)
    else $error("irq0 not following pin A6");
  AST_CS_IDLE: assert property (input_select_two_reg[CS_SRC_BIT] && !(bus_wr_in && hit_two)
    |=> chip_select_out == IDLE_LEVEL)
    else $error("reserved chip select not idle");
  AST_CAP0_E1: assert property (input_select_one_reg[CAP0_SRC_BIT] && !(bus_wr_in && hit_one)
    |=> std_timer0_capture_out == $past(pin_w[PORT_E_PIN1]))
    else $error("capture 0 not following pin E1");
  AST_AN_FORCE: assert property (read_port_enable_reg && an_chan_sel_in[0]
    |=> an_switch_out[0])
    else $error("selected analog path not forced closed");
  AST_AN_OPEN: assert property (!read_port_enable_reg && !an_func_sel_in[0]
    |=> !an_switch_out[0])
    else $error("analog path closed without function");
  AST_RP_READ: assert property (bus_rd_in && hit_data && port_idx == 3'h0 && read_port_enable_reg
    && !pin_analog_in[0] && !pin_reset_in[0] |=> bus_rdata_out[0] == $past(pin_w[0]))
    else $error("read-port read not pin level");
  AST_WAKE: assert property (sleep_in && wake_en_reg[0] && pa_prev_reg[0] && !pin_w[0]
    |=> wake_out)
    else $error("no wake on falling Port A pin");

  // Sleep gating, reserved codes and analog read-back
  AST_NO_WAKE_AWAKE: assert property (!sleep_in |=> !wake_out)
    else $error("wake raised while awake");

  AST_URX1_IDLE: assert property (!input_select_three_reg[URX1_SRC_BIT]
    |=> uart1_rx_out == IDLE_LEVEL)
    else $error("reserved uart1 receive not idle");

  AST_SEL2_RSVD: assert property (bus_rd_in && hit_two |=> !bus_rdata_out[7])
    else $error("unimplemented select two bit reads nonzero");

  AST_RB_ANALOG: assert property (bus_rd_in && hit_data && port_idx == 3'h0
    && pin_analog_in[2] |=> !bus_rdata_out[2])
    else $error("analog pin read back nonzero");

  // Main scenarios worth seeing at least once
  COV_KEY: cover property (bus_wr_in && hit_key && key_match ##1 bus_rd_in && hit_data);
  COV_BITOP: cover property (bop_go && !bop_dir);
  COV_WAKE: cover property (sleep_in ##1 wake_out);
  COV_RSV_IDLE: cover property (input_select_two_reg[CS_SRC_BIT] ##1 chip_select_out);
  COV_AN_FORCE: cover property (read_port_enable_reg && an_chan_sel_in[0] && !an_func_sel_in[0]);

endmodule // io_input_select_readport

// ===== hdl/io_sel_pkg.sv
/*
  Constants shared by the port-side input selection and read-back logic:
  register offsets, field positions, reset values and pin positions.
  Assumes a byte-wide register port and five 8-bit ports A, B, C, E, F.
*/
package io_sel_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] OFS_SEL_ONE = 8'h00;
  localparam logic [7:0] OFS_SEL_TWO = 8'h01;
  localparam logic [7:0] OFS_SEL_THREE = 8'h02;
  localparam logic [7:0] OFS_KEY = 8'h03;
  localparam logic [7:0] OFS_WAKE_EN = 8'h04;
  localparam logic [7:0] OFS_BIT_OP = 8'h05;
  localparam logic [4:0] OFS_DATA_BLK = 5'h02; // Port data latches at 0x10..0x14
  localparam logic [4:0] OFS_DIR_BLK = 5'h03; // Port direction bits at 0x18..0x1C

  // Implemented bit masks of the selection registers
  localparam logic [7:0] MASK_SEL_ONE = 8'h7F;
  localparam logic [7:0] MASK_SEL_TWO = 8'h7F;
  localparam logic [7:0] MASK_SEL_THREE = 8'h03;

  // Reset values
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_KEY = 8'h00;
  localparam logic [7:0] RST_PORT = 8'hFF;
  localparam logic [7:0] RST_WAKE_EN = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Unlock pattern for the read-port function
  localparam logic [7:0] READ_PORT_KEY_VAL = 8'hCA;

  // Field positions in input_select_one
  localparam int CAP0_SRC_BIT = 0;
  localparam int CAP1_SRC_BIT = 1;
  // Field positions in input_select_two
  localparam int IRQ0_SRC_BIT = 0;
  localparam int IRQ1_SRC_BIT = 1;
  localparam int IRQ2_SRC_BIT = 2;
  localparam int IRQ3_SRC_BIT = 3;
  localparam int SCLK_SRC_BIT = 4;
  localparam int SDATA_SRC_BIT = 5;
  localparam int CS_SRC_BIT = 6;
  // Field positions in input_select_three
  localparam int URX0_SRC_BIT = 0;
  localparam int URX1_SRC_BIT = 1;
  // Field positions of the bit-operation command word
  localparam int BOP_DIR_BIT = 7;
  localparam int BOP_PORT_LSB = 4;
  localparam int BOP_VAL_BIT = 3;

  // Pin positions in the flat pin vector (port index times 8 plus bit)
  localparam int PORT_A_PIN1 = 1;
  localparam int PORT_A_PIN3 = 3;
  localparam int PORT_A_PIN4 = 4;
  localparam int PORT_A_PIN5 = 5;
  localparam int PORT_A_PIN6 = 6;
  localparam int PORT_A_PIN7 = 7;
  localparam int PORT_B_PIN6 = 14;
  localparam int PORT_C_PIN6 = 22;
  localparam int PORT_C_PIN7 = 23;
  localparam int PORT_E_PIN1 = 25;
  localparam int PORT_F_PIN6 = 38;

  // Level a peripheral input sees when no pin is routed to it
  localparam logic IDLE_LEVEL = 1'b1;

endpackage

// ===== hdl/pin_bus_if.sv
/*
  Carries raw pin levels into the synchroniser and the settled levels out.
  Assumes both ends run on the single system clock.
*/
`timescale 1ns/1ps
interface pin_bus_if #(parameter int WIDTH = 40);
  logic [WIDTH-1:0] raw; // Levels straight from the pads
  logic [WIDTH-1:0] stable; // Levels after the three-stage filter
  modport sync_side (input raw, output stable);
  modport user_side (output raw, input stable);
endinterface

// ===== hdl/pin_sync.sv
/*
  Three-stage pin synchroniser with agreement filter, one per pin.
  Assumes pins are asynchronous to clk_in; pins idle high via pull-ups.
*/
`timescale 1ns/1ps
module pin_sync
  import io_sel_pkg::*;
#(
  parameter int WIDTH = 40
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Pin levels in and settled levels out
  pin_bus_if.sync_side pins
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_reg; // Metastable stage, read only by s2
      logic s2_reg;
      logic s3_reg;
      logic stable_reg; // Value seen by the rest of the block

      // Shift chain; a change counts once stages two and three agree
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          s1_reg <= IDLE_LEVEL;
          s2_reg <= IDLE_LEVEL;
          s3_reg <= IDLE_LEVEL;
          stable_reg <= IDLE_LEVEL;
        end else begin
          s1_reg <= pins.raw[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // Disagreement holds the old value, filtering one-cycle glitches
          if (s2_reg == s3_reg) begin
            stable_reg <= s3_reg;
          end
        end
      end

      assign pins.stable[i] = stable_reg;
    end
  endgenerate

endmodule // pin_sync

// ===== verif/ext_pin_world.sv
/*
  Board-side model of the circuitry on the shared I/O pins.
  Assumes pull-ups on every pin; the bench may drive any pin it owns.
*/
`timescale 1ns/1ps
module ext_pin_world #(
  parameter int WIDTH = 40
) (
  // Pad drive from the device
  input wire logic [WIDTH-1:0] port_data_in,
  input wire logic [WIDTH-1:0] port_oe_in,
  // Outside drivers set by the bench
  input wire logic [WIDTH-1:0] ext_drv_in,
  input wire logic [WIDTH-1:0] ext_val_in,
  // Resolved pad level
  output logic [WIDTH-1:0] pin_level_out
);
  // Device wins where it drives; an undriven pin floats up to the pull-up
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (port_oe_in[i]) begin
        pin_level_out[i] = port_data_in[i];
      end else if (ext_drv_in[i]) begin
        pin_level_out[i] = ext_val_in[i];
      end else begin
        pin_level_out[i] = 1'b1;
      end
    end
  end
endmodule // ext_pin_world

// ===== verif/tb_io_input_select_readport.sv
/*
  Self-checking bench for the input selection and read-back block.
  Assumes the package offsets and a 40 MHz clock; pins resolve in ext_pin_world.
*/
`timescale 1ns/1ps
module tb_io_input_select_readport;
  import io_sel_pkg::*;
  logic clk_in, nrst_in, bus_wr, bus_rd, sleep;
  logic [7:0] bus_addr, bus_wdata, bus_rdata;
  logic [39:0] pins, pdata, poe, ext_drv, ext_val, c_per, c_com, c_ana, c_rst;
  logic [3:0] an_func, an_chan, an_sw;
  logic [10:0] rt; // Routed peripheral inputs, cap0 at bit 0
  logic rp_en, wake;
  int err_total, tests_run;

  // Device under test
  io_input_select_readport dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .bus_addr_in(bus_addr), .bus_wdata_in(bus_wdata), .bus_wr_in(bus_wr),
    .bus_rd_in(bus_rd), .bus_rdata_out(bus_rdata), .pin_level_in(pins),
    .pin_periph_out_in(c_per), .pin_comm_in(c_com), .pin_analog_in(c_ana),
    .pin_reset_in(c_rst), .port_data_out(pdata), .port_oe_out(poe),
    .an_func_sel_in(an_func), .an_chan_sel_in(an_chan), .an_switch_out(an_sw),
    .std_timer0_capture_out(rt[0]), .std_timer1_capture_out(rt[1]),
    .chip_select_out(rt[2]), .serial_data_out(rt[3]), .serial_clock_out(rt[4]),
    .ext_irq0_out(rt[5]), .ext_irq1_out(rt[6]), .ext_irq2_out(rt[7]),
    .ext_irq3_out(rt[8]), .uart0_rx_out(rt[9]), .uart1_rx_out(rt[10]),
    .read_port_enable_out(rp_en), .sleep_in(sleep), .wake_out(wake));

  // Outside world on the pads
  ext_pin_world world (.port_data_in(pdata), .port_oe_in(poe), .ext_drv_in(ext_drv),
    .ext_val_in(ext_val), .pin_level_out(pins));

  // 25 ns clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_in);
    bus_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_in);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  // Pad change needs four edges through the filter and one more to a routed input; one spare
  task automatic settle;
    repeat (6) @(posedge clk_in);
    #1;
  endtask

  // Source pin low then high must show on the routed input, or idle if reserved
  task automatic route(input logic [7:0] a, input logic [7:0] v, input int pin,
                       input int idx, input logic rsv);
    wr(a, v);
    ext_drv[pin] <= 1'b1;
    ext_val[pin] <= 1'b0;
    settle;
    chk({7'h00, rt[idx]}, {7'h00, rsv});
    ext_val[pin] <= 1'b1;
    settle;
    chk({7'h00, rt[idx]}, 8'h01);
    ext_drv[pin] <= 1'b0;
  endtask

  // Reset state of ports, selection and key registers
  task automatic reset_values;
    logic [7:0] d;
    for (int p = 0; p < 5; p++) begin
      rd(8'h18 + 8'(p), d);
      chk(d, 8'hFF);
      chk(pdata[p*8 +: 8], 8'hFF);
      chk(poe[p*8 +: 8], 8'h00);
    end
    for (int a = 0; a < 4; a++) begin
      rd(8'(a), d);
      chk(d, 8'h00);
    end
    chk({7'h00, rp_en}, 8'h00);
    chk({5'h00, rt[2:0]}, 8'h07);
  endtask

  // Unimplemented bits and unmapped places
  task automatic reg_access;
    logic [7:0] d;
    wr(8'h01, 8'hFF);
    rd(8'h01, d);
    chk(d, 8'h7F);
    wr(8'h02, 8'hFF);
    rd(8'h02, d);
    chk(d, 8'h03);
    rd(8'h07, d);
    chk(d, 8'h00);
    rd(8'h05, d);
    chk(d, 8'h00);
  endtask

  // Every source code of every field, reserved ones included
  task automatic routing;
    route(8'h00, 8'h00, PORT_C_PIN6, 0, 1'b0);
    route(8'h00, 8'h01, PORT_E_PIN1, 0, 1'b0);
    route(8'h00, 8'h02, PORT_B_PIN6, 1, 1'b0);
    route(8'h00, 8'h00, PORT_B_PIN6, 1, 1'b1);
    route(8'h01, 8'h00, PORT_A_PIN1, 2, 1'b0);
    route(8'h01, 8'h40, PORT_A_PIN1, 2, 1'b1);
    route(8'h01, 8'h00, PORT_A_PIN4, 3, 1'b0);
    route(8'h01, 8'h20, PORT_A_PIN4, 3, 1'b1);
    route(8'h01, 8'h00, PORT_A_PIN5, 4, 1'b0);
    route(8'h01, 8'h10, PORT_A_PIN5, 4, 1'b1);
    route(8'h01, 8'h00, PORT_A_PIN1, 5, 1'b0);
    route(8'h01, 8'h01, PORT_A_PIN6, 5, 1'b0);
    route(8'h01, 8'h00, PORT_A_PIN3, 6, 1'b0);
    route(8'h01, 8'h02, PORT_A_PIN7, 6, 1'b0);
    route(8'h01, 8'h00, PORT_A_PIN4, 7, 1'b0);
    route(8'h01, 8'h04, PORT_A_PIN4, 7, 1'b1);
    route(8'h01, 8'h00, PORT_A_PIN5, 8, 1'b0);
    route(8'h01, 8'h08, PORT_C_PIN7, 8, 1'b0);
    route(8'h02, 8'h00, PORT_A_PIN6, 9, 1'b0);
    route(8'h02, 8'h01, PORT_A_PIN6, 9, 1'b1);
    route(8'h02, 8'h02, PORT_F_PIN6, 10, 1'b0);
    route(8'h02, 8'h00, PORT_F_PIN6, 10, 1'b1);
  endtask

  // Falling enabled pin wakes once; a pin not enabled stays quiet
  task automatic wake_test;
    int hits;
    hits = 0;
    wr(8'h04, 8'h01);
    sleep <= 1'b1;
    ext_drv[0] <= 1'b1;
    ext_val[0] <= 1'b0;
    repeat (12) begin
      @(posedge clk_in);
      #1 if (wake === 1'b1) hits++;
    end
    chk(8'(hits), 8'h01);
    hits = 0;
    ext_drv[2] <= 1'b1;
    ext_val[2] <= 1'b0;
    repeat (12) begin
      @(posedge clk_in);
      #1 if (wake === 1'b1) hits++;
    end
    chk(8'(hits), 8'h00);
    ext_drv <= '0;
    sleep <= 1'b0;
    settle;
    // Awake: the same enabled pin falling again must not wake
    hits = 0;
    ext_drv[0] <= 1'b1;
    repeat (12) begin
      @(posedge clk_in);
      #1 if (wake === 1'b1) hits++;
    end
    chk(8'(hits), 8'h00);
    ext_drv <= '0;
  endtask

  // Port A classes: pin 0 periph out, pin 1 comm, pin 2 analog, pin 3 reset
  task automatic readback;
    logic [7:0] d;
    wr(8'h10, 8'h58);
    wr(8'h18, 8'hF0);
    ext_drv[7:0] <= 8'hF0;
    ext_val[7:0] <= 8'h90;
    settle;
    rd(8'h10, d);
    chk(d, 8'h90);
    wr(8'h18, 8'hFF);
    ext_drv[7:0] <= 8'hFF;
    ext_val[7:0] <= 8'h97;
    settle;
    rd(8'h10, d);
    chk(d, 8'h92);
    wr(8'h03, 8'hCA);
    #1 chk({7'h00, rp_en}, 8'h01);
    rd(8'h10, d);
    chk(d, 8'h93);
    an_chan <= 4'h1;
    repeat (2) @(posedge clk_in);
    #1 chk({4'h0, an_sw}, 8'h01);
    wr(8'h03, 8'hCB);
    #1 chk({7'h00, rp_en}, 8'h00);
    rd(8'h03, d);
    chk(d, 8'hCB);
    repeat (2) @(posedge clk_in);
    #1 chk({4'h0, an_sw}, 8'h00);
    an_func <= 4'h1;
    repeat (2) @(posedge clk_in);
    #1 chk({4'h0, an_sw}, 8'h01);
    rd(8'h10, d);
    chk(d, 8'h92);
    ext_drv <= '0;
  endtask

  // Bit clear goes through the whole-port read-back; the direction bit set reads dir_reg
  task automatic bit_ops;
    wr(8'h19, 8'hF0);
    ext_drv[15:8] <= 8'hF0;
    ext_val[15:8] <= 8'h00;
    settle;
    wr(8'h05, 8'h11);
    #1 chk(pdata[15:8], 8'h0D);
    wr(8'h05, 8'h99);
    #1 chk(poe[15:8], 8'h0D);
    ext_drv <= '0;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    end_sim;
  end

  // Main sequence
  initial begin
    err_total = 0;
    tests_run = 0;
    nrst_in = 1'b0;
    {bus_wr, bus_rd, sleep} = '0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    ext_drv = '0;
    ext_val = '0;
    c_per = 40'h01;
    c_com = 40'h02;
    c_ana = 40'h04;
    c_rst = 40'h08;
    an_func = 4'h0;
    an_chan = 4'h0;
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    settle;
    reset_values;
    reg_access;
    routing;
    wake_test;
    readback;
    bit_ops;
    end_sim;
  end
endmodule // tb_io_input_select_readport
